// ==== hdl/pie_irq_enable.v ====
// What this block does
// - Unused bits read zero, ignore writes.
// - Enable-one bit 6 gates ADC interrupt.
// - Enable-one bit 5 gates serial receive.
// - Enable-one bit 4 gates serial transmit.
// - Enable-one bit 3 gates synchronous serial.
// - Enable-one bit 2 gates capture/compare A.
// - Enable-one bit 1 gates period match.
// - Enable-one bit 0 gates timer overflow.
// - Enable-two bit 7 gates oscillator fail.
// - Enable-two bit 6 gates comparator B.
// - Enable-two bit 5 gates comparator A.
// - Enable-two bit 4 gates EEPROM write.
// - Enable-two bit 3 gates bus collision.
// - Enable-two bit 2 gates low-power wake.
// - Enable-two bit 0 gates capture/compare B.
// - Group enable required for any request.
// - Flags set regardless of enables.
// - Global enable blocks every interrupt at coreIrq_reg; periphIrq_reg ignores it.
`default_nettype none
`include "pie_regs.vh"

module pie_irq_enable (
   input wire sys_clk,
   input wire reset_n,
   // AXI4-Lite slave.
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // One-cycle event pulses from the sources, same clock domain.
   input wire [7:0] srcEventOne,
   input wire [7:0] srcEventTwo,
   // Peripheral request to the core and the globally gated request.
   output reg periphIrq_reg,
   output reg coreIrq_reg
);

   ////////////////////////////////////////////////////////////////////////
   // Register state.
   // The flags live in the two banks below; only the settings are here.
   reg [7:0] enOne_reg;
   reg [7:0] enTwo_reg;
   reg [1:0] coreCtrl_reg;
   wire [7:0] flagOne;
   wire [7:0] flagTwo;
   reg [7:0] clrOne;
   reg [7:0] clrTwo;

   // Write channel state.
   reg [4:0] awAddr_reg;
   reg awHeld_reg;
   reg [31:0] wData_reg;
   reg [3:0] wStrb_reg;
   reg wHeld_reg;
   wire doWrite;
   wire [4:0] awAddrNow;
   wire [31:0] wDataNow;
   wire [3:0] wStrbNow;
   wire awTake;
   wire wTake;
   reg wrMapped;

   ////////////////////////////////////////////////////////////////////////
   // Flag banks; unimplemented positions never set.
   // The events come from logic on this clock, so they enter the banks
   // with no synchroniser; a source on another clock must bring its own.
   pie_flag_bank #(
      .IMPL_MASK(`PIE_MASK_ONE)
   ) u_flag_one (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .eventIn(srcEventOne),
      .clearIn(clrOne),
      .flag_reg(flagOne)
   );

   pie_flag_bank #(
      .IMPL_MASK(`PIE_MASK_TWO)
   ) u_flag_two (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .eventIn(srcEventTwo),
      .clearIn(clrTwo),
      .flag_reg(flagTwo)
   );

   ////////////////////////////////////////////////////////////////////////
   // Address and data are taken in either order and held until both
   // are present; the write then happens in one cycle.
   assign awTake = s_axi_awvalid && s_axi_awready;
   assign wTake = s_axi_wvalid && s_axi_wready;
   assign awAddrNow = awHeld_reg ? awAddr_reg : s_axi_awaddr;
   assign wDataNow = wHeld_reg ? wData_reg : s_axi_wdata;
   assign wStrbNow = wHeld_reg ? wStrb_reg : s_axi_wstrb;
   assign doWrite = (awHeld_reg || awTake) && (wHeld_reg || wTake);

   // Write decode; flags clear by writing ones to the flag registers.
   // A write to the status word is answered but changes nothing, since
   // the two requests there are results, not settings.
   always @* begin
      clrOne = 8'h00;
      clrTwo = 8'h00;
      wrMapped = 1'b1;
      case (awAddrNow)
         {1'b0, `PIE_ADDR_EN_ONE}, {1'b0, `PIE_ADDR_EN_TWO},
         `PIE_ADDR_CTRL: begin
            wrMapped = 1'b1;
         end
         {1'b0, `PIE_ADDR_FLAG_ONE}: begin
            if (doWrite && wStrbNow[0]) begin
               clrOne = wDataNow[7:0];
            end
         end
         {1'b0, `PIE_ADDR_FLAG_TWO}: begin
            if (doWrite && wStrbNow[0]) begin
               clrTwo = wDataNow[7:0];
            end
         end
         `PIE_ADDR_STATUS: begin
            wrMapped = 1'b1;
         end
         default: begin
            wrMapped = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Write channel handshake and response.
   // Whichever half arrives first is parked in the held registers, and its
   // ready drops so the master cannot overwrite it before the pair is whole.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PIE_RESP_OKAY;
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 5'h00;
         wData_reg <= 32'h00000000;
         wStrb_reg <= 4'h0;
      end else begin
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? `PIE_RESP_OKAY : `PIE_RESP_SLVERR;
         end else begin
            if (awTake) begin
               awHeld_reg <= 1'b1;
               awAddr_reg <= s_axi_awaddr;
            end
            if (wTake) begin
               wHeld_reg <= 1'b1;
               wData_reg <= s_axi_wdata;
               wStrb_reg <= s_axi_wstrb;
            end
            // Ready stays low while a response waits, so one write at once.
            s_axi_awready <= !s_axi_bvalid && !awHeld_reg && !awTake;
            s_axi_wready <= !s_axi_bvalid && !wHeld_reg && !wTake;
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
               s_axi_awready <= 1'b1;
               s_axi_wready <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable and core control registers; reserved bits are dropped here.
   // Only the low byte lane matters: every setting fits in eight bits, so
   // a write with strobe 0 clear leaves all of them untouched.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         enOne_reg <= `PIE_RST_EN;
         enTwo_reg <= `PIE_RST_EN;
         coreCtrl_reg <= `PIE_RST_CTRL;
      end else if (doWrite && wStrbNow[0]) begin
         if (awAddrNow == {1'b0, `PIE_ADDR_EN_ONE}) begin
            enOne_reg <= wDataNow[7:0] & `PIE_MASK_ONE;
         end
         if (awAddrNow == {1'b0, `PIE_ADDR_EN_TWO}) begin
            enTwo_reg <= wDataNow[7:0] & `PIE_MASK_TWO;
         end
         if (awAddrNow == `PIE_ADDR_CTRL) begin
            coreCtrl_reg <= wDataNow[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one read at a time, answer one cycle after the take.
   reg [31:0] rdValue;
   reg rdMapped;

   // Read decode; unmapped words read zero and answer with an error.
   always @* begin
      rdValue = 32'h00000000;
      rdMapped = 1'b1;
      case (s_axi_araddr)
         {1'b0, `PIE_ADDR_EN_ONE}: begin
            rdValue = {24'h000000, enOne_reg};
         end
         {1'b0, `PIE_ADDR_EN_TWO}: begin
            rdValue = {24'h000000, enTwo_reg};
         end
         {1'b0, `PIE_ADDR_FLAG_ONE}: begin
            rdValue = {24'h000000, flagOne};
         end
         {1'b0, `PIE_ADDR_FLAG_TWO}: begin
            rdValue = {24'h000000, flagTwo};
         end
         `PIE_ADDR_STATUS: begin
            rdValue = {30'h00000000, coreIrq_reg, periphIrq_reg};
         end
         `PIE_ADDR_CTRL: begin
            rdValue = {30'h00000000, coreCtrl_reg};
         end
         default: begin
            rdMapped = 1'b0;
         end
      endcase
   end

   // Read handshake. The word is captured at the take, so it stands still
   // while the master waits even if a flag sets meanwhile; the cost is that
   // a slow master reads a value one or more cycles old.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PIE_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdValue;
            s_axi_rresp <= rdMapped ? `PIE_RESP_OKAY : `PIE_RESP_SLVERR;
         end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
               s_axi_arready <= 1'b1;
            end
         end else begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request logic. Each flag is ANDed with its own enable bit. A flag
   // left set before enabling fires at once, which is why software must
   // clear stale flags first; the block itself cannot tell a stale event
   // from a fresh one.
   wire adcPass;
   wire rxPass;
   wire txPass;
   wire syncSerialPass;
   wire captureAPass;
   wire periodPass;
   wire overflowPass;
   wire oscFailPass;
   wire compBPass;
   wire compAPass;
   wire eepromPass;
   wire collisionPass;
   wire wakePass;
   wire captureBPass;
   wire anyPass;
   reg periphIrq_next;
   reg coreIrq_next;

   // First enable register; bit 7 has no source behind it.
   assign adcPass = flagOne[6] & enOne_reg[6];
   assign rxPass = flagOne[5] & enOne_reg[5];
   assign txPass = flagOne[4] & enOne_reg[4];
   assign syncSerialPass = flagOne[3] & enOne_reg[3];
   assign captureAPass = flagOne[2] & enOne_reg[2];
   assign periodPass = flagOne[1] & enOne_reg[1];
   assign overflowPass = flagOne[0] & enOne_reg[0];

   // Second enable register; bit 1 has no source behind it.
   assign oscFailPass = flagTwo[7] & enTwo_reg[7];
   assign compBPass = flagTwo[6] & enTwo_reg[6];
   assign compAPass = flagTwo[5] & enTwo_reg[5];
   assign eepromPass = flagTwo[4] & enTwo_reg[4];
   assign collisionPass = flagTwo[3] & enTwo_reg[3];
   assign wakePass = flagTwo[2] & enTwo_reg[2];
   assign captureBPass = flagTwo[0] & enTwo_reg[0];

   // Any single passing source is enough to ask for service.
   assign anyPass = adcPass | rxPass | txPass | syncSerialPass
      | captureAPass | periodPass | overflowPass | oscFailPass | compBPass
      | compAPass | eepromPass | collisionPass | wakePass | captureBPass;

   // Next values of the two requests. The group gate sits on the
   // peripheral request itself, so a core that only looks at the global
   // request never sees a source whose group is masked.
   always @* begin
      periphIrq_next = anyPass & coreCtrl_reg[`PIE_CTRL_GROUP];
      coreIrq_next = periphIrq_next;
      if (!coreCtrl_reg[`PIE_CTRL_GLOBAL]) begin
         coreIrq_next = 1'b0;
      end
   end

   // Both requests leave the block straight from flip-flops, one cycle
   // after the flag or enable that causes them.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         periphIrq_reg <= 1'b0;
         coreIrq_reg <= 1'b0;
      end else begin
         periphIrq_reg <= periphIrq_next;
         coreIrq_reg <= coreIrq_next;
      end
   end

endmodule // pie_irq_enable

`default_nettype wire

// ==== hdl/pie_regs.vh ====
`ifndef PIE_REGS_VH
`define PIE_REGS_VH

// Byte addresses of the registers on the AXI4-Lite bus.
`define PIE_ADDR_EN_ONE 4'h0
`define PIE_ADDR_EN_TWO 4'h4
`define PIE_ADDR_FLAG_ONE 4'h8
`define PIE_ADDR_FLAG_TWO 4'hc
`define PIE_ADDR_CORE_CTRL 4'h0
`define PIE_ADDR_STATUS 5'h10
`define PIE_ADDR_CTRL 5'h14

// Implemented bits of the two enable registers and the two flag registers.
`define PIE_MASK_ONE 8'h7f
`define PIE_MASK_TWO 8'hfd

// Reset values.
`define PIE_RST_EN 8'h00
`define PIE_RST_FLAG 8'h00
`define PIE_RST_CTRL 2'h0

// Field positions in the core control register.
`define PIE_CTRL_GLOBAL 1
`define PIE_CTRL_GROUP 0

// AXI response codes.
`define PIE_RESP_OKAY 2'h0
`define PIE_RESP_SLVERR 2'h2

`endif

// ==== hdl/pie_flag_bank.v ====
`default_nettype none

// One bank of eight sticky interrupt flags with software clear.
module pie_flag_bank #(
   parameter [7:0] IMPL_MASK = 8'hff
) (
   input wire sys_clk,
   input wire reset_n,
   input wire [7:0] eventIn,
   input wire [7:0] clearIn,
   output reg [7:0] flag_reg
);

   ////////////////////////////////////////////////////////////////////////
   // Flags set whatever the masks are; a set in the clear cycle wins.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_reg <= 8'h00;
      end else begin
         flag_reg <= ((flag_reg & ~clearIn) | eventIn) & IMPL_MASK;
      end
   end

endmodule // pie_flag_bank

`default_nettype wire

// ==== tb/pie_irq_props.sv ====
`default_nettype none
`include "pie_regs.vh"
// Watches the register bus handshake and the two request outputs.
module pie_irq_props (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] srcEventOne,
   input wire logic [7:0] srcEventTwo,
   input wire logic periphIrq_reg,
   input wire logic coreIrq_reg
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] rdAddr_reg;
   logic evSeen_reg;
   // Keeps the read address, since rdata arrives a cycle after it.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdAddr_reg <= 5'h00;
         evSeen_reg <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) rdAddr_reg <= s_axi_araddr;
         evSeen_reg <= |{srcEventOne, srcEventTwo};
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence wrTake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rdTake;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (wrTake |=> s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (rdTake |=> s_axi_rvalid)
      else $error("read response late");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_busy_refuse: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("ready while busy");
   a_unused_zero: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h0 &&
      !(rdAddr_reg == `PIE_ADDR_EN_ONE && s_axi_rdata[7]) &&
      !(rdAddr_reg == `PIE_ADDR_EN_TWO && s_axi_rdata[1]))
      else $error("unused bit set");
   a_group_gate: assert property (coreIrq_reg |-> periphIrq_reg)
      else $error("core request without group");
   a_irq_cause: assert property ($rose(periphIrq_reg) |->
      $past(s_axi_bvalid) || $past(evSeen_reg))
      else $error("request without cause");
   a_reset_quiet: assert property (disable iff (1'b0)
      !reset_n |-> !periphIrq_reg && !coreIrq_reg && !s_axi_bvalid)
      else $error("active during reset");
endmodule // pie_irq_props
bind pie_irq_enable pie_irq_props pie_irq_props_i (.sys_clk, .reset_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .srcEventOne, .srcEventTwo, .periphIrq_reg,
   .coreIrq_reg);
`default_nettype wire

// ==== tb/pie_src_model.sv ====
`default_nettype none
// The peripheral sources: each request becomes a one-cycle event pulse.
module pie_src_model (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [15:0] fireReq,
   output logic [7:0] srcEventOne,
   output logic [7:0] srcEventTwo
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pulses land on a clock edge, so the block sees a clean single cycle.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) {srcEventTwo, srcEventOne} <= 16'h0000;
      else {srcEventTwo, srcEventOne} <= fireReq;
   end
endmodule // pie_src_model
`default_nettype wire

// ==== tb/test_peripheral_irq_enable_mask.sv ====
`default_nettype none
`include "pie_regs.vh"
// Drives the block over its register bus and checks it against a model.
module test_peripheral_irq_enable_mask;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int IMPL = 32'h0000fd7f;
   logic sys_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic periphIrq_reg, coreIrq_reg;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] srcEventOne, srcEventTwo;
   logic [15:0] fireReq;
   int nMismatch, comparisons, cycles, en, fl, ctl;
   pie_irq_enable pie_irq_enable_i (.sys_clk, .reset_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .srcEventOne, .srcEventTwo, .periphIrq_reg, .coreIrq_reg);
   pie_src_model pie_src_model_i (.sys_clk, .reset_n, .fireReq,
      .srcEventOne, .srcEventTwo);
   // The clock, 100 ns period.
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // A run far past its expected length has hung.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         nMismatch = nMismatch + 1;
         test_done();
      end
   end
   ////////////////////////////////////////
   task test_done();
      if (nMismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp) begin
         nMismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic mPer();
      return ((fl & en) != 0) && ctl[0];
   endfunction
   function automatic logic [33:0] mRead(input logic [4:0] a);
      case (a)
         `PIE_ADDR_EN_ONE: return {26'h0, en[7:0]};
         `PIE_ADDR_EN_TWO: return {26'h0, en[15:8]};
         `PIE_ADDR_FLAG_ONE: return {26'h0, fl[7:0]};
         `PIE_ADDR_FLAG_TWO: return {26'h0, fl[15:8]};
         `PIE_ADDR_STATUS: return {32'h0, mPer() && ctl[1], mPer()};
         `PIE_ADDR_CTRL: return {32'h0, ctl[1:0]};
         default: return {`PIE_RESP_SLVERR, 32'h0};
      endcase
   endfunction
   // Bus write; the model follows once the response is in.
   task setReg(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, mRead(a) >> 32);
      case (a)
         `PIE_ADDR_EN_ONE: en[7:0] = d & `PIE_MASK_ONE;
         `PIE_ADDR_EN_TWO: en[15:8] = d & `PIE_MASK_TWO;
         `PIE_ADDR_FLAG_ONE: fl[7:0] = fl[7:0] & ~d;
         `PIE_ADDR_FLAG_TWO: fl[15:8] = fl[15:8] & ~d;
         `PIE_ADDR_CTRL: ctl = d;
         default: ;
      endcase
   endtask
   task getReg(input logic [4:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk({s_axi_rresp, s_axi_rdata}, mRead(a));
   endtask
   task chkIrq();
      repeat (3) @(posedge sys_clk);
      chk({coreIrq_reg, periphIrq_reg}, {mPer() && ctl[1], mPer()});
   endtask
   // Unimplemented event bits must leave no flag behind.
   task fire(input logic [15:0] v);
      @(posedge sys_clk);
      fireReq <= v;
      @(posedge sys_clk);
      fireReq <= 16'h0000;
      fl = fl | (v & IMPL);
      chkIrq();
   endtask
   ////////////////////////////////////////
   initial begin
      logic [4:0] fa, ea;
      reset_n = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      fireReq = 16'h0000;
      // Reset falls after time zero so every flop sees a clean edge.
      #10 reset_n = 1'b0;
      void'($urandom(32'h9a6bd6ea));
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int a = 0; a < 28; a += 4) getReg(5'(a));
      setReg(`PIE_ADDR_EN_ONE, 8'hff);
      setReg(`PIE_ADDR_EN_TWO, 8'hff);
      setReg(5'h18, 8'hff);
      for (int a = 0; a < 28; a += 4) getReg(5'(a));
      setReg(`PIE_ADDR_EN_ONE, 8'h00);
      setReg(`PIE_ADDR_EN_TWO, 8'h00);
      setReg(`PIE_ADDR_CTRL, 8'h03);
      // Each source: flag while masked, clear, enable, then pass.
      for (int i = 0; i < 16; i++) if (IMPL[i]) begin
         fa = (i < 8) ? `PIE_ADDR_FLAG_ONE : `PIE_ADDR_FLAG_TWO;
         ea = (i < 8) ? `PIE_ADDR_EN_ONE : `PIE_ADDR_EN_TWO;
         fire(16'(1 << i));
         getReg(fa);
         setReg(fa, 8'hff);
         setReg(ea, 8'(1 << (i % 8)));
         fire(16'(1 << i));
         setReg(fa, 8'hff);
         chkIrq();
         setReg(ea, 8'h00);
      end
      // An event in the very cycle of its clear must survive the clear.
      fork
         fire(16'h0001);
         begin
            @(posedge sys_clk);
            setReg(`PIE_ADDR_FLAG_ONE, 8'hff);
         end
      join
      fl = fl | 32'h00000001;
      getReg(`PIE_ADDR_FLAG_ONE);
      // Random mixes of group, global, enables and events.
      repeat (40) begin
         setReg(`PIE_ADDR_CTRL, 8'($urandom));
         setReg(`PIE_ADDR_EN_ONE, 8'($urandom));
         setReg(`PIE_ADDR_EN_TWO, 8'($urandom));
         fire(16'($urandom) & 16'($urandom));
         getReg(`PIE_ADDR_STATUS);
         getReg(`PIE_ADDR_FLAG_TWO);
         setReg(`PIE_ADDR_FLAG_ONE, 8'($urandom));
      end
      // A reset in mid-run must mask every source again.
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      en = 0;
      fl = 0;
      ctl = 0;
      for (int a = 0; a < 28; a += 4) getReg(5'(a));
      chkIrq();
      test_done();
   end
endmodule // test_peripheral_irq_enable_mask
`default_nettype wire
